// [hw/mdio_c45_defines.vh]
// constants for the clause 45 management frame slave
`ifndef MDIO_C45_DEFINES_VH
`define MDIO_C45_DEFINES_VH

// ==========================================================
// register byte addresses
`define OFS_BLOCK_CONTROL 32'h40005c00
`define OFS_FRAME_INFO 32'h40005c04
`define OFS_WRITE_DATA 32'h40005c08
`define OFS_TARGET_ADDR 32'h40005c0c
`define OFS_READ_REPLY 32'h40005c10
`define OFS_EXPECT_SEL 32'h40005c14
`define OFS_STATUS 32'h40005c18
`define OFS_IRQ_ENABLE 32'h40005c1c
`define OFS_PIN_READBACK 32'h40005c20

// ==========================================================
// reset values
`define RST_BLOCK_CONTROL 3'h0
`define RST_EXPECT_SEL 15'h0400
`define RST_READ_REPLY 16'h0000
`define RST_STATUS 8'h00
`define RST_IRQ_ENABLE 8'h00

// ==========================================================
// block_control fields
`define CTL_SOFT_RESET 0
`define CTL_MATCH_WIDTH 1
`define CTL_DRIVE_STYLE 2

// ==========================================================
// expected_address_select fields
`define SEL_SW_LO 0
`define SEL_SW_HI 4
`define SEL_SRC_LO 5
`define SEL_SRC_HI 9
`define SEL_DEV_LO 10
`define SEL_DEV_HI 14

// ==========================================================
// frame_progress_status bits
`define STA_WRITE_DONE 0
`define STA_ADDR_DONE 1
`define STA_INC_DONE 2
`define STA_READ_DONE 3
`define STA_DEV_MATCH 4
`define STA_DEV_MISS 5
`define STA_PHYS_MATCH 6
`define STA_PHYS_MISS 7

// ==========================================================
// frame layout
`define PREAMBLE_BITS 6'd32
`define LAST_OP_BIT 4'd1
`define LAST_ADDR_BIT 4'd4
`define LAST_TA_BIT 4'd1
`define LAST_DATA_BIT 4'd15
`define OP_ADDRESS 2'b00
`define OP_WRITE 2'b01
`define OP_READ_INC 2'b10
`define OP_READ 2'b11

// ==========================================================
// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// [hw/mdio_clause45_slave.v]
// clause 45 management frame slave with axi4-lite register port
// Operation
// (RULE1) frame is 32 preamble plus 32 body
// (RULE2) all fields shift most significant first
// (RULE3) host sends 32 or more preamble ones
// (RULE4) two zero start bits open frame info
// (RULE5) opcode: address, write, read, read-increment
// (RULE6) read-increment leaves stored address to software
// (RULE7) host turnaround 10; device drives z0, data
// (RULE8) idle line undriven; host drives otherwise
// (RULE9) five-bit physical address compared to expected
// (RULE10) device address field selects device type
// (RULE11) address/data field is sixteen bits
// (RULE12) capture address frame and write frame words
// (RULE13) transmit reply register shifted out on reads
// (RULE14) control bit 2 picks open-drain/push-pull
// (RULE15) control bit 1 picks five/three bit match
// (RULE16) control bit 0 soft reset, self clearing
// (RULE17) frame info: dev 11:7, phy 6:2, op
// (RULE18) status register clears when read
// (RULE19) software clears status before enabling events
// (RULE20) mismatched address frames cause no action
// (RULE21) match/mismatch flags after phy and dev fields
// (RULE22) end-of-frame flag per type, enable gated
// (RULE23) per-bit expected source: pin or software
// (RULE24) sync lines, sample on clock rise
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "mdio_c45_defines.vh"

module mdio_clause45_slave #(
  parameter ADDR_W = 32,
  parameter PHYS_W = 5
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // axi4-lite write address
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  // axi4-lite write response
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  output wire [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  // axi4-lite read data
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  // management link
  input wire mdc_i,
  input wire mdio_i,
  output wire mdio_o,
  output wire mdio_oe_o,
  // address straps and event request
  input wire [PHYS_W-1:0] port_address_pins_i,
  output wire event_request_o
);

  localparam S_PRE = 3'h0;
  localparam S_ST2 = 3'h1;
  localparam S_OP = 3'h2;
  localparam S_PHY = 3'h3;
  localparam S_DEV = 3'h4;
  localparam S_TA = 3'h5;
  localparam S_DATA = 3'h6;

  // ==========================================================
  // synchronisers
  reg mdc_s1_q, mdc_s2_q, mdc_s3_q;
  reg mdio_s1_q, mdio_s2_q;
  reg [PHYS_W-1:0] pins_s1_q, pins_s2_q;
  wire mdc_rise;
  wire bit_in;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mdc_s1_q <= 1'b0;
      mdc_s2_q <= 1'b0;
      mdc_s3_q <= 1'b0;
      mdio_s1_q <= 1'b1;
      mdio_s2_q <= 1'b1;
      pins_s1_q <= {PHYS_W{1'b0}};
      pins_s2_q <= {PHYS_W{1'b0}};
    end else begin
      mdc_s1_q <= mdc_i; // RULE24
      mdc_s2_q <= mdc_s1_q;
      mdc_s3_q <= mdc_s2_q;
      mdio_s1_q <= mdio_i;
      mdio_s2_q <= mdio_s1_q;
      pins_s1_q <= port_address_pins_i;
      pins_s2_q <= pins_s1_q;
    end
  end

  // both lines go through equal depth so bit and edge stay aligned
  assign mdc_rise = mdc_s2_q & ~mdc_s3_q; // RULE24
  assign bit_in = mdio_s2_q;

  // ==========================================================
  // software registers
  reg match_width_q, drive_style_q, soft_rst_q;
  reg [14:0] expect_sel_q;
  reg [15:0] read_reply_word_q;
  reg [7:0] irq_enable_q;
  reg [7:0] status_q;
  reg [11:0] frame_info_q;
  reg [15:0] write_data_q, target_addr_q;

  // ==========================================================
  // expected address
  wire [PHYS_W-1:0] exp_phys;
  wire [PHYS_W-1:0] sw_bits;
  wire [PHYS_W-1:0] src_sel;
  wire [4:0] exp_dev;
  assign sw_bits = expect_sel_q[`SEL_SW_HI:`SEL_SW_LO];
  assign src_sel = expect_sel_q[`SEL_SRC_HI:`SEL_SRC_LO];
  assign exp_dev = expect_sel_q[`SEL_DEV_HI:`SEL_DEV_LO];

  genvar g;
  generate
    for (g = 0; g < PHYS_W; g = g + 1) begin : g_exp
      assign exp_phys[g] = src_sel[g] ? sw_bits[g] : pins_s2_q[g]; // RULE23
    end
  endgenerate

  // ==========================================================
  // frame receiver
  reg [2:0] state_q;
  reg [5:0] pre_cnt_q;
  reg [3:0] bit_cnt_q;
  reg [15:0] shift_q;
  reg [1:0] op_q;
  reg [4:0] phy_q;
  reg phy_ok_q, frame_ok_q;
  reg [15:0] tx_shift_q;
  reg drv_en_q, drv_bit_q;
  reg [7:0] status_set;
  wire [15:0] shift_nx;
  wire [4:0] phy_nx;
  wire phy_hit;
  wire is_read;

  assign shift_nx = {shift_q[14:0], bit_in}; // RULE2
  assign phy_nx = shift_nx[4:0];
  assign phy_hit = match_width_q ?
    (phy_nx[2:0] == exp_phys[2:0]) : (phy_nx == exp_phys); // RULE9 RULE15
  assign is_read = op_q[1]; // RULE5

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= S_PRE;
      pre_cnt_q <= 6'h00;
      bit_cnt_q <= 4'h0;
      shift_q <= 16'h0000;
      op_q <= 2'b00;
      phy_q <= 5'h00;
      phy_ok_q <= 1'b0;
      frame_ok_q <= 1'b0;
      tx_shift_q <= 16'h0000;
      drv_en_q <= 1'b0;
      drv_bit_q <= 1'b1;
      frame_info_q <= 12'h000;
      write_data_q <= 16'h0000;
      target_addr_q <= 16'h0000;
      status_set <= 8'h00;
    end else if (soft_rst_q) begin
      state_q <= S_PRE; // RULE16
      pre_cnt_q <= 6'h00;
      bit_cnt_q <= 4'h0;
      drv_en_q <= 1'b0;
      drv_bit_q <= 1'b1;
      status_set <= 8'h00;
    end else begin
      status_set <= 8'h00;
      if (mdc_rise) begin
        shift_q <= shift_nx;
        bit_cnt_q <= bit_cnt_q + 4'h1;
        case (state_q)
          S_PRE: begin
            if (bit_in) begin
              if (pre_cnt_q != `PREAMBLE_BITS) begin
                pre_cnt_q <= pre_cnt_q + 6'h01; // RULE3
              end
            end else if (pre_cnt_q == `PREAMBLE_BITS) begin
              state_q <= S_ST2; // RULE1 RULE4
            end else begin
              pre_cnt_q <= 6'h00;
            end
          end
          S_ST2: begin
            bit_cnt_q <= 4'h0;
            pre_cnt_q <= bit_in ? 6'h01 : 6'h00;
            state_q <= bit_in ? S_PRE : S_OP; // RULE4
          end
          S_OP: begin
            if (bit_cnt_q == `LAST_OP_BIT) begin
              op_q <= shift_nx[1:0]; // RULE5
              bit_cnt_q <= 4'h0;
              state_q <= S_PHY;
            end
          end
          S_PHY: begin
            if (bit_cnt_q == `LAST_ADDR_BIT) begin
              phy_q <= phy_nx;
              phy_ok_q <= phy_hit;
              status_set[`STA_PHYS_MATCH] <= phy_hit; // RULE21
              status_set[`STA_PHYS_MISS] <= ~phy_hit;
              bit_cnt_q <= 4'h0;
              state_q <= S_DEV;
            end
          end
          S_DEV: begin
            if (bit_cnt_q == `LAST_ADDR_BIT) begin
              // device address acts as device-type selector
              frame_ok_q <= phy_ok_q & (phy_nx == exp_dev); // RULE10 RULE20
              status_set[`STA_DEV_MATCH] <= (phy_nx == exp_dev); // RULE21
              status_set[`STA_DEV_MISS] <= (phy_nx != exp_dev);
              if (phy_ok_q && phy_nx == exp_dev) begin
                frame_info_q <= {phy_nx, phy_q, op_q}; // RULE17
              end
              bit_cnt_q <= 4'h0;
              state_q <= S_TA;
            end
          end
          S_TA: begin
            if (bit_cnt_q != `LAST_TA_BIT) begin
              // host has let go; reply word must be loaded by now
              if (is_read && frame_ok_q) begin
                drv_en_q <= 1'b1; // RULE7
                drv_bit_q <= 1'b0;
                tx_shift_q <= read_reply_word_q; // RULE13
              end
            end else begin
              if (drv_en_q) begin
                drv_bit_q <= tx_shift_q[15]; // RULE2
                tx_shift_q <= {tx_shift_q[14:0], 1'b0};
              end
              bit_cnt_q <= 4'h0;
              state_q <= S_DATA;
            end
          end
          S_DATA: begin
            if (bit_cnt_q != `LAST_DATA_BIT) begin
              if (drv_en_q) begin
                drv_bit_q <= tx_shift_q[15]; // RULE24
                tx_shift_q <= {tx_shift_q[14:0], 1'b0};
              end
            end else begin
              drv_en_q <= 1'b0; // RULE8
              drv_bit_q <= 1'b1;
              bit_cnt_q <= 4'h0;
              pre_cnt_q <= 6'h00;
              state_q <= S_PRE;
              if (frame_ok_q) begin
                case (op_q)
                  `OP_ADDRESS: begin
                    target_addr_q <= shift_nx; // RULE11 RULE12
                    status_set[`STA_ADDR_DONE] <= 1'b1; // RULE22
                  end
                  `OP_WRITE: begin
                    write_data_q <= shift_nx; // RULE12
                    status_set[`STA_WRITE_DONE] <= 1'b1; // RULE22
                  end
                  // address is not advanced here
                  `OP_READ_INC: begin
                    status_set[`STA_INC_DONE] <= 1'b1; // RULE6 RULE22
                  end
                  default: begin
                    status_set[`STA_READ_DONE] <= 1'b1; // RULE22
                  end
                endcase
              end
            end
          end
          default: begin
            state_q <= S_PRE;
            pre_cnt_q <= 6'h00;
          end
        endcase
      end
    end
  end

  // open drain only ever pulls low
  assign mdio_oe_o = drv_en_q & (drive_style_q | ~drv_bit_q); // RULE14
  assign mdio_o = drv_bit_q & drive_style_q; // RULE14

  // ==========================================================
  // axi4-lite slave
  reg aw_held_q, w_held_q, bvalid_q, rvalid_q;
  reg [ADDR_W-1:0] aw_addr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg [1:0] bresp_q, rresp_q;
  reg [31:0] rdata_q;
  reg [31:0] rd_val;
  reg rd_hit;
  wire do_write;
  wire do_read;
  wire wr_lo, wr_hi;
  wire status_clr;

  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready = ~w_held_q & ~bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign do_write = aw_held_q & w_held_q & ~bvalid_q;
  assign do_read = s_axi_arvalid & ~rvalid_q;
  assign wr_lo = do_write & wstrb_q[0];
  assign wr_hi = do_write & wstrb_q[1];
  assign status_clr = do_read & (s_axi_araddr == `OFS_STATUS);

  always @* begin
    rd_hit = 1'b1;
    rd_val = 32'h00000000;
    case (s_axi_araddr)
      `OFS_BLOCK_CONTROL: rd_val[2:1] = {drive_style_q, match_width_q};
      `OFS_FRAME_INFO: rd_val[11:0] = frame_info_q;
      `OFS_WRITE_DATA: rd_val[15:0] = write_data_q;
      `OFS_TARGET_ADDR: rd_val[15:0] = target_addr_q;
      `OFS_READ_REPLY: rd_val[15:0] = read_reply_word_q;
      `OFS_EXPECT_SEL: rd_val[14:0] = expect_sel_q;
      `OFS_STATUS: rd_val[7:0] = status_q;
      `OFS_IRQ_ENABLE: rd_val[7:0] = irq_enable_q;
      `OFS_PIN_READBACK: rd_val[PHYS_W-1:0] = pins_s2_q;
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      aw_addr_q <= {ADDR_W{1'b0}};
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bresp_q <= `RESP_OKAY;
      rresp_q <= `RESP_OKAY;
      rdata_q <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        case (aw_addr_q)
          `OFS_BLOCK_CONTROL, `OFS_FRAME_INFO, `OFS_WRITE_DATA,
          `OFS_TARGET_ADDR, `OFS_READ_REPLY, `OFS_EXPECT_SEL,
          `OFS_STATUS, `OFS_IRQ_ENABLE, `OFS_PIN_READBACK:
            bresp_q <= `RESP_OKAY;
          default: bresp_q <= `RESP_SLVERR;
        endcase
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (do_read) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_val;
        rresp_q <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // register writes and status
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {drive_style_q, match_width_q, soft_rst_q} <= `RST_BLOCK_CONTROL;
      expect_sel_q <= `RST_EXPECT_SEL;
      read_reply_word_q <= `RST_READ_REPLY;
      irq_enable_q <= `RST_IRQ_ENABLE;
      status_q <= `RST_STATUS;
    end else begin
      soft_rst_q <= 1'b0; // RULE16
      if (wr_lo && aw_addr_q == `OFS_BLOCK_CONTROL) begin
        drive_style_q <= wdata_q[`CTL_DRIVE_STYLE]; // RULE14
        match_width_q <= wdata_q[`CTL_MATCH_WIDTH]; // RULE15
        soft_rst_q <= wdata_q[`CTL_SOFT_RESET]; // RULE16
      end
      if (aw_addr_q == `OFS_READ_REPLY) begin
        if (wr_lo) begin
          read_reply_word_q[7:0] <= wdata_q[7:0]; // RULE13
        end
        if (wr_hi) begin
          read_reply_word_q[15:8] <= wdata_q[15:8];
        end
      end
      if (aw_addr_q == `OFS_EXPECT_SEL) begin
        if (wr_lo) begin
          expect_sel_q[7:0] <= wdata_q[7:0]; // RULE23
        end
        if (wr_hi) begin
          expect_sel_q[14:8] <= wdata_q[14:8];
        end
      end
      if (wr_lo && aw_addr_q == `OFS_IRQ_ENABLE) begin
        irq_enable_q <= wdata_q[7:0]; // RULE22
      end
      // a flag raised in the clearing cycle survives
      if (soft_rst_q) begin
        status_q <= `RST_STATUS;
      end else begin
        status_q <= (status_q & {8{~status_clr}}) | status_set; // RULE18
      end
    end
  end

  // level request, no latch of its own
  assign event_request_o = |(status_q & irq_enable_q); // RULE22 RULE19

endmodule // mdio_clause45_slave

`default_nettype wire

// [bench/mdio_c45_monitor.sv]
// assertion checker bound to the management frame slave
`timescale 1ns/1ps
`default_nettype none
`include "mdio_c45_defines.vh"
module mdio_c45_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // link
  input wire logic mdc_i,
  input wire logic mdio_oe_o
);
  // ==========================================
  // age of the last link clock rise
  logic mdc_q;
  logic [2:0] age_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mdc_q <= 1'h0;
      age_q <= 3'h7;
    end else begin
      mdc_q <= mdc_i;
      if (mdc_i && !mdc_q)
        age_q <= 3'h0;
      else if (age_q != 3'h7)
        age_q <= age_q + 3'h1;
    end
  end

  // ==========================================
  // properties
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_wr_ans;
    // both halves held one cycle, register written, then answer
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_w_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_refuse: assert property (p_w_refuse) else $error("write taken early");
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > `OFS_PIN_READBACK
      |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_ctl_bit0;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFS_BLOCK_CONTROL
      |=> !s_axi_rdata[0];
  endproperty
  a_ctl_bit0: assert property (p_ctl_bit0) else $error("reset bit set");
  // drive changes only shortly after a link clock rise
  property p_drive_time;
    $changed(mdio_oe_o) |-> age_q != 3'h7;
  endproperty
  a_drive_time: assert property (p_drive_time) else $error("drive late");
endmodule // mdio_c45_monitor

bind mdio_clause45_slave mdio_c45_monitor u_mon (
  .clk_i, .rst_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .mdc_i, .mdio_oe_o
);
`default_nettype wire

// [bench/mdio_host_model.sv]
// station management host model that drives the link
`timescale 1ns/1ps
`default_nettype none
module mdio_host_model (
  // link to the device
  output logic mdc_o,
  output logic drv_o,
  output logic oe_o,
  input wire logic line_i
);
  // ==========================================
  // bit and frame timing, 400 ns link period
  initial begin
    mdc_o = 1'h0;
    drv_o = 1'h0;
    oe_o = 1'h0;
  end

  // data moves while the clock is low, sampled just before the rise
  task automatic bit_cyc(input logic d, en, output logic s);
    oe_o = en;
    drv_o = d;
    #200;
    s = line_i;
    mdc_o = 1'h1;
    #200;
    mdc_o = 1'h0;
  endtask

  task automatic frame(input int np, input logic [1:0] op,
    input logic [4:0] p, dv, input logic [15:0] d,
    output logic [15:0] q, output logic ta);
    logic [13:0] h;
    logic s;
    int i;
    h = {2'h0, op, p, dv};
    // keeps link edges off the system clock edges
    #13;
    for (i = 0; i < np; i++) bit_cyc(1'h1, 1'h1, s);
    for (i = 13; i >= 0; i--) bit_cyc(h[i], 1'h1, s);
    bit_cyc(1'h1, !op[1], s);
    bit_cyc(1'h0, !op[1], ta);
    for (i = 15; i >= 0; i--) begin
      bit_cyc(d[i], !op[1], s);
      q[i] = s;
    end
    oe_o = 1'h0;
  endtask
endmodule // mdio_host_model
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench for the management frame slave
`timescale 1ns/1ps
`default_nettype none
`include "mdio_c45_defines.vh"
module testbench;
  // ==========================================
  // signals
  logic clk_i = 1'h0, rst_i = 1'h1, pp = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
  logic [31:0] s_axi_araddr = 32'h0, v;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [4:0] port_address_pins_i = 5'h0, phy;
  logic [14:0] sw;
  logic [15:0] tx, d, q, e_info = 16'h0, e_adr = 16'h0, e_rxd = 16'h0;
  logic [1:0] r;
  logic ta;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire logic s_axi_rvalid, mdio_o, mdio_oe_o, event_request_o;
  wire logic mdc_i, mdio_i, h_drv, h_oe;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  int n_mismatch = 0, comparisons = 0, i, m, o;
  integer seed = 32'hb5fc7d0e;

  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (mdio_oe_o && mdio_o) pp <= 1'h1;

  mdio_clause45_slave u_dut (
    .clk_i, .rst_i, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .mdc_i, .mdio_i, .mdio_o, .mdio_oe_o, .port_address_pins_i,
    .event_request_o
  );
  mdio_host_model u_host (
    .mdc_o(mdc_i), .drv_o(h_drv), .oe_o(h_oe), .line_i(mdio_i)
  );
  // released line floats high through the pull-up
  assign mdio_i = mdio_oe_o ? mdio_o : (h_oe ? h_drv : 1'h1);

  // ==========================================
  // tasks
  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [31:0] a, dat, output logic [1:0] rs);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (!s_axi_bready) s_axi_bready <= 1'($random(seed));
    end while (!(s_axi_bvalid && s_axi_bready) && n < 200);
    s_axi_bready <= 1'h0;
    rs = s_axi_bresp;
    chk("bvalid", 32'h1, s_axi_bvalid);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] qd,
    output logic [1:0] rs);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (!s_axi_rready) s_axi_rready <= 1'($random(seed));
    end while (!(s_axi_rvalid && s_axi_rready) && n < 200);
    s_axi_rready <= 1'h0;
    qd = s_axi_rdata;
    rs = s_axi_rresp;
    chk("rvalid", 32'h1, s_axi_rvalid);
  endtask

  task automatic rc(input string n, input logic [31:0] a, e);
    logic [31:0] qd;
    logic [1:0] rs;
    rd(a, qd, rs);
    chk(n, e, qd);
    chk(n, `RESP_OKAY, rs);
  endtask

  task automatic run(input logic [2:0] c, input logic [14:0] s,
    input logic [1:0] op, input logic [4:0] p, dv, input int np,
    input logic [7:0] st, mk);
    d = 16'($random(seed));
    tx = 16'($random(seed)) | 16'h1;
    wr(`OFS_BLOCK_CONTROL, c, r);
    wr(`OFS_EXPECT_SEL, s, r);
    wr(`OFS_READ_REPLY, tx, r);
    rd(`OFS_STATUS, v, r);
    wr(`OFS_IRQ_ENABLE, 32'hff, r);
    pp = 1'h0;
    u_host.frame(np, op, p, dv, d, q, ta);
    repeat (8) @(posedge clk_i);
    chk("event", 32'(st != 8'h0), event_request_o);
    rd(`OFS_STATUS, v, r);
    chk("status", st, v & mk);
    rc("status", `OFS_STATUS, 32'h0);
    if (st[3:0] != 4'h0) begin
      e_info = {4'h0, dv, p, op};
      if (op == 2'h0) e_adr = d;
      if (op == 2'h1) e_rxd = d;
      if (op[1]) begin
        chk("reply", tx, q);
        chk("ta", 32'h0, ta);
        chk("style", c[2], pp);
      end
    end else if (op[1]) chk("reply", 32'hffff, q);
    rc("info", `OFS_FRAME_INFO, e_info);
    rc("adr", `OFS_TARGET_ADDR, e_adr);
    rc("rxd", `OFS_WRITE_DATA, e_rxd);
    $display("test frame op %b done", op);
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================
  // sequence
  initial begin
    port_address_pins_i <= 5'($random(seed));
    phy = 5'($random(seed));
    sw = 15'h7e0 | {10'h0, phy};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'h0;
    for (i = 0; i < 9; i++)
      rc("reset", 32'h40005c00 + 4 * i,
        i == 5 ? 32'h400 : i == 8 ? {27'h0, port_address_pins_i} : 32'h0);
    rd(32'h40005c24, v, r);
    chk("rresp", `RESP_SLVERR, r);
    wr(32'h40005c24, 32'h1, r);
    chk("bresp", `RESP_SLVERR, r);
    wr(`OFS_FRAME_INFO, 32'hfff, r);
    rc("info", `OFS_FRAME_INFO, 32'h0);
    wr(`OFS_BLOCK_CONTROL, 32'h7, r);
    rc("control", `OFS_BLOCK_CONTROL, 32'h6);
    $display("test registers done");
    for (m = 0; m < 2; m++)
      for (o = 0; o < 4; o++)
        run(3'(m * 4), sw, 2'(o), phy, 5'h1, 32,
          8'h50 | (8'h1 << (o < 2 ? 1 - o : o)), 8'hff);
    run(3'h0, sw, 2'h3, phy ^ 5'h1, 5'h1, 32, 8'h80, 8'hcf);
    run(3'h0, sw, 2'h3, phy, 5'h2, 32, 8'h60, 8'hff);
    run(3'h2, sw, 2'h0, phy ^ 5'h10, 5'h1, 32, 8'h52, 8'hff);
    run(3'h0, sw, 2'h0, phy ^ 5'h10, 5'h1, 32, 8'h80, 8'hcf);
    run(3'h0, 15'h400, 2'h1, port_address_pins_i, 5'h1, 32, 8'h51,
      8'hff);
    run(3'h0, 15'h400, 2'h1, port_address_pins_i, 5'h1, 31, 8'h0,
      8'hff);
    d = 16'($random(seed));
    u_host.frame(32, 2'h0, port_address_pins_i, 5'h1, d, q, ta);
    repeat (8) @(posedge clk_i);
    // pending flags must stay silent while masked
    wr(`OFS_IRQ_ENABLE, 32'h0, r);
    chk("event", 32'h0, event_request_o);
    wr(`OFS_IRQ_ENABLE, 32'h2, r);
    chk("event", 32'h1, event_request_o);
    wr(`OFS_BLOCK_CONTROL, 32'h1, r);
    rc("status", `OFS_STATUS, 32'h0);
    rc("adr", `OFS_TARGET_ADDR, d);
    $display("test soft reset done");
    final_report;
  end

  // roughly fifteen frames of 25.6 us plus register traffic
  initial begin
    #2000000;
    n_mismatch++;
    final_report;
  end
endmodule // testbench
`default_nettype wire
